// ==== src/afe_pkg.sv ====
// What this block does
// - One low ready pulse per finished conversion
// - Ready idles driven high or released
// - Pulse width half sample period, rate-spaced
// - Ready free-running, independent of serial port
// - Master clock from oscillator or input pin
// - Host keeps prescaled analog clock in range
// - Transaction framed by chip select edges
// - Serial traffic ignored during master reset
// - Sample input rising, update output falling
// - Modes 0,0 and 1,1; switch while deselected
// - Serial clock asynchronous, 20 MHz maximum
// - Output released except during read data
// - Half-duplex: never receive and send together
// - Every transaction opens with 8-bit command
// - Input ignored after read command
// - Master reset restores defaults, stops clocks
// - Converters run straight after reset release
// - Analog clock is master clock over 1/2/4/8
// - Sample clock is analog clock over four
// - Ready rate is sample clock over ratio
package afe_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS     = 4;
  localparam int SCK_MIN_PERIOD_NS = 50;
  localparam int SCK_HALF_CYC      = (SCK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_CNT_W         = 4;

  // ----------------------------------------
  // Serial framing
  // ----------------------------------------
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [3:0] HOST_LAST    = 4'hf;
  localparam logic [6:0] ADDR_CFG     = 7'h00;
  localparam logic [6:0] ADDR_STAT    = 7'h01;

  // ----------------------------------------
  // Device configuration byte
  // ----------------------------------------
  localparam int         CFG_PRE_LSB  = 0;
  localparam int         CFG_RATE_LSB = 2;
  localparam int         CFG_IDLE_BIT = 5;
  localparam int         CFG_EXT_BIT  = 6;
  localparam logic [7:0] CFG_RESET    = 8'h0c;
  localparam int         RATE_BASE_SH = 5;
  localparam int         SAMP_DIV_SH  = 2;
  localparam int         RDY_CNT_W    = 18;

  // ----------------------------------------
  // Host Avalon registers
  // ----------------------------------------
  localparam logic [3:0]  HOST_CTRL_OFS = 4'h0;
  localparam logic [3:0]  HOST_STAT_OFS = 4'h4;
  localparam int          CTRL_GO_BIT   = 0;
  localparam int          CTRL_RSTN_BIT = 1;
  localparam int          CTRL_MODE_BIT = 2;
  localparam int          CTRL_EXT_BIT  = 3;
  localparam int          CTRL_CMD_LSB  = 8;
  localparam int          CTRL_WD_LSB   = 16;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0002;

  typedef enum logic [1:0] {
    AFE_PH_CMD = 2'b00,
    AFE_PH_WR  = 2'b01,
    AFE_PH_RD  = 2'b11
  } afe_phase_t;

  typedef enum logic [1:0] {
    AFE_H_IDLE = 2'b00,
    AFE_H_LO   = 2'b01,
    AFE_H_HI   = 2'b11,
    AFE_H_TAIL = 2'b10
  } afe_hstate_t;

endpackage

// ==== src/afe_link_if.sv ====
`timescale 1ns/1ns
interface afe_link_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic conversion_ready_n;
  logic conversion_ready_oe;
  logic mreset_n;
  logic clock_input_pin;
  logic sdo_line;
  logic ready_line;

  // ----------------------------------------
  // Released lines read as pulled high
  // ----------------------------------------
  assign sdo_line   = sdo_oe ? sdo : 1'b1;
  assign ready_line = conversion_ready_oe ? conversion_ready_n : 1'b1;

  modport dev (
    input  cs_n, sck, sdi, mreset_n, clock_input_pin,
    output sdo, sdo_oe, conversion_ready_n, conversion_ready_oe
  );

  modport host (
    output cs_n, sck, sdi, mreset_n, clock_input_pin,
    input  sdo_line, ready_line
  );
endinterface

// ==== src/afe_ready_gen.sv ====
`timescale 1ns/1ns
module afe_ready_gen (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       mclk_tick_i,
  input  wire logic [1:0] prescale_i,
  input  wire logic [2:0] oversampling_ratio_i,
  output logic            ready_low_o
);
  localparam int W = afe_pkg::RDY_CNT_W;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] period;
  logic [W-1:0] width;
  logic         low_q;
  logic         low_d;

  // ----------------------------------------
  // Period and width in master clock ticks
  // ----------------------------------------
  always_comb begin
    period = W'(1) << (afe_pkg::SAMP_DIV_SH + afe_pkg::RATE_BASE_SH + 32'(prescale_i)
             + 32'(oversampling_ratio_i));
    width  = W'(2) << prescale_i;
    cnt_d  = cnt_q;
    low_d  = low_q;
    if (mclk_tick_i) begin
      // Wrap also when a shorter period was just selected
      cnt_d = (cnt_q >= period - W'(1)) ? '0 : cnt_q + W'(1);
      low_d = (cnt_d >= period - width);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      low_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      low_q <= low_d;
    end
  end

  assign ready_low_o = low_q;
endmodule

// ==== src/afe_dev_end.sv ====
`timescale 1ns/1ns
module afe_dev_end #(
  parameter int OSC_DIV = 16
) (
  input  wire logic  sys_clk_i,
  input  wire logic  sys_rst_i,
  afe_link_if.dev    link,
  output logic [7:0] config_o,
  output logic [7:0] sample_count_o,
  output logic       ready_low_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic sdi_s1_q, sdi_s2_q;
  logic rstn_s1_q, rstn_s2_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_s3_q   <= 1'b1;
      sck_s1_q  <= 1'b0;
      sck_s2_q  <= 1'b0;
      sck_s3_q  <= 1'b0;
      sdi_s1_q  <= 1'b0;
      sdi_s2_q  <= 1'b0;
      rstn_s1_q <= 1'b0;
      rstn_s2_q <= 1'b0;
      ck_s1_q   <= 1'b0;
      ck_s2_q   <= 1'b0;
      ck_s3_q   <= 1'b0;
    end else begin
      cs_s1_q   <= link.cs_n;
      cs_s2_q   <= cs_s1_q;
      cs_s3_q   <= cs_s2_q;
      sck_s1_q  <= link.sck;
      sck_s2_q  <= sck_s1_q;
      sck_s3_q  <= sck_s2_q;
      sdi_s1_q  <= link.sdi;
      sdi_s2_q  <= sdi_s1_q;
      rstn_s1_q <= link.mreset_n;
      rstn_s2_q <= rstn_s1_q;
      ck_s1_q   <= link.clock_input_pin;
      ck_s2_q   <= ck_s1_q;
      ck_s3_q   <= ck_s2_q;
    end
  end

  logic dev_rst;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;

  assign dev_rst  = sys_rst_i | ~rstn_s2_q;
  assign sck_rise = sck_s2_q & ~sck_s3_q;
  assign sck_fall = ~sck_s2_q & sck_s3_q;
  assign cs_fall  = ~cs_s2_q & cs_s3_q;

  // ----------------------------------------
  // Master clock source
  // ----------------------------------------
  localparam int OW = $clog2(OSC_DIV + 1);

  logic [7:0]    cfg_q;
  logic [OW-1:0] osc_q;
  logic [OW-1:0] osc_d;
  logic          mclk_tick;
  logic          ext_sel;

  assign ext_sel = cfg_q[afe_pkg::CFG_EXT_BIT];

  always_comb begin
    osc_d = '0;
    if (!ext_sel) begin
      osc_d = (osc_q == OW'(OSC_DIV - 1)) ? '0 : osc_q + OW'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      osc_q <= '0;
    end else begin
      osc_q <= osc_d;
    end
  end

  assign mclk_tick = ext_sel ? (ck_s2_q & ~ck_s3_q) : (osc_q == OW'(OSC_DIV - 1));

  // ----------------------------------------
  // Ready pulse
  // ----------------------------------------
  logic ready_low;

  afe_ready_gen u_ready (
    .sys_clk_i            (sys_clk_i),
    .rst_i                (dev_rst),
    .mclk_tick_i          (mclk_tick),
    .prescale_i           (cfg_q[afe_pkg::CFG_PRE_LSB +: 2]),
    .oversampling_ratio_i (cfg_q[afe_pkg::CFG_RATE_LSB +: 3]),
    .ready_low_o          (ready_low)
  );

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  afe_pkg::afe_phase_t phase_q, phase_d;
  logic [2:0]          bit_q, bit_d;
  logic [7:0]          shin_q, shin_d;
  logic [6:0]          addr_q, addr_d;
  logic [7:0]          shout_q, shout_d;
  logic                sdo_q, sdo_d;
  logic                oe_q, oe_d;
  logic [7:0]          cfg_d;
  logic [7:0]          nsamp_q, nsamp_d;
  logic                low_prev_q;
  logic [7:0]          rd_val;

  always_comb begin
    case (addr_q)
      afe_pkg::ADDR_CFG:  rd_val = cfg_q;
      afe_pkg::ADDR_STAT: rd_val = nsamp_q;
      default:            rd_val = 8'h00;
    endcase
  end

  always_comb begin
    phase_d = phase_q;
    bit_d   = bit_q;
    shin_d  = shin_q;
    addr_d  = addr_q;
    shout_d = shout_q;
    sdo_d   = sdo_q;
    oe_d    = oe_q;
    cfg_d   = cfg_q;
    nsamp_d = nsamp_q;
    if (ready_low && !low_prev_q) begin
      nsamp_d = nsamp_q + 8'h01;
    end
    if (cs_s2_q || cs_fall) begin
      phase_d = afe_pkg::AFE_PH_CMD;
      bit_d   = 3'h0;
      oe_d    = 1'b0;
    end else begin
      if (sck_rise && phase_q != afe_pkg::AFE_PH_RD) begin
        shin_d = {shin_q[6:0], sdi_s2_q};
        bit_d  = bit_q + 3'h1;
        if (bit_q == afe_pkg::LAST_BIT) begin
          if (phase_q == afe_pkg::AFE_PH_CMD) begin
            addr_d  = shin_d[7:1];
            phase_d = shin_d[0] ? afe_pkg::AFE_PH_RD : afe_pkg::AFE_PH_WR;
          end else if (addr_q == afe_pkg::ADDR_CFG) begin
            cfg_d = shin_d;
          end
        end
      end
      if (sck_fall && phase_q == afe_pkg::AFE_PH_RD) begin
        bit_d = bit_q + 3'h1;
        oe_d  = 1'b1;
        if (bit_q == 3'h0) begin
          sdo_d   = rd_val[7];
          shout_d = {rd_val[6:0], 1'b0};
        end else begin
          sdo_d   = shout_q[7];
          shout_d = {shout_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      phase_q    <= afe_pkg::AFE_PH_CMD;
      bit_q      <= 3'h0;
      shin_q     <= 8'h00;
      addr_q     <= 7'h00;
      shout_q    <= 8'h00;
      sdo_q      <= 1'b0;
      oe_q       <= 1'b0;
      cfg_q      <= afe_pkg::CFG_RESET;
      nsamp_q    <= 8'h00;
      low_prev_q <= 1'b0;
    end else begin
      phase_q    <= phase_d;
      bit_q      <= bit_d;
      shin_q     <= shin_d;
      addr_q     <= addr_d;
      shout_q    <= shout_d;
      sdo_q      <= sdo_d;
      oe_q       <= oe_d;
      cfg_q      <= cfg_d;
      nsamp_q    <= nsamp_d;
      low_prev_q <= ready_low;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  assign link.sdo                 = sdo_q;
  assign link.sdo_oe              = oe_q & ~cs_s2_q;
  assign link.conversion_ready_n  = ~ready_low;
  assign link.conversion_ready_oe = ready_low | cfg_q[afe_pkg::CFG_IDLE_BIT];
  assign config_o                 = cfg_q;
  assign sample_count_o           = nsamp_q;
  assign ready_low_o              = ready_low;
endmodule

// ==== src/afe_host_end.sv ====
`timescale 1ns/1ns
module afe_host_end #(
  parameter int EXT_HALF = 8
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  afe_link_if.host         link,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);
  localparam int CW = afe_pkg::SCK_CNT_W;
  localparam int EW = $clog2(EXT_HALF + 1);

  afe_pkg::afe_hstate_t st_q, st_d;
  logic [31:0]   ctrl_q, ctrl_d;
  logic [CW-1:0] hc_q, hc_d;
  logic [3:0]    bit_q, bit_d;
  logic [15:0]   sh_q, sh_d;
  logic [7:0]    rx_q, rx_d;
  logic          cs_q, cs_d;
  logic          sck_q, sck_d;
  logic          sdi_q, sdi_d;
  logic          rdack_q, rdack_d;
  logic [31:0]   rdata_q, rdata_d;
  logic [EW-1:0] ext_q, ext_d;
  logic          clk_q, clk_d;
  logic          half_done;
  logic          wr_ctrl;
  logic          mode11;
  logic [7:0]    cmd;

  assign half_done = (hc_q == CW'(afe_pkg::SCK_HALF_CYC - 1));
  assign wr_ctrl   = avs_write_i && avs_address_i == afe_pkg::HOST_CTRL_OFS;
  assign mode11    = ctrl_q[afe_pkg::CTRL_MODE_BIT];
  assign cmd       = ctrl_q[afe_pkg::CTRL_CMD_LSB +: 8];

  always_comb begin
    st_d    = st_q;
    ctrl_d  = ctrl_q;
    hc_d    = half_done ? '0 : hc_q + CW'(1);
    bit_d   = bit_q;
    sh_d    = sh_q;
    rx_d    = rx_q;
    cs_d    = cs_q;
    sck_d   = sck_q;
    sdi_d   = sdi_q;
    rdack_d = avs_read_i & ~rdack_q;
    rdata_d = 32'h0;
    case (avs_address_i)
      afe_pkg::HOST_CTRL_OFS: rdata_d = ctrl_q;
      afe_pkg::HOST_STAT_OFS: rdata_d = {16'h0, rx_q, 6'h0, link.ready_line, st_q != afe_pkg::AFE_H_IDLE};
      default:                rdata_d = 32'h0;
    endcase
    ext_d = (ext_q == EW'(EXT_HALF - 1)) ? '0 : ext_q + EW'(1);
    clk_d = (ext_q == EW'(EXT_HALF - 1)) ? ~clk_q : clk_q;
    if (!ctrl_q[afe_pkg::CTRL_EXT_BIT]) begin
      clk_d = 1'b0;
    end
    case (st_q)
      afe_pkg::AFE_H_IDLE: begin
        hc_d  = '0;
        sck_d = mode11;
        if (wr_ctrl) begin
          ctrl_d = avs_writedata_i & ~(32'h1 << afe_pkg::CTRL_GO_BIT);
          if (avs_writedata_i[afe_pkg::CTRL_GO_BIT]) begin
            sh_d  = {avs_writedata_i[afe_pkg::CTRL_CMD_LSB +: 8],
                     avs_writedata_i[afe_pkg::CTRL_CMD_LSB] ? 8'h00 : avs_writedata_i[afe_pkg::CTRL_WD_LSB +: 8]};
            cs_d  = 1'b0;
            sck_d = 1'b0;
            sdi_d = avs_writedata_i[afe_pkg::CTRL_CMD_LSB + 7];
            bit_d = 4'h0;
            st_d  = afe_pkg::AFE_H_LO;
          end
        end
      end
      afe_pkg::AFE_H_LO: begin
        if (half_done) begin
          sck_d = 1'b1;
          st_d  = afe_pkg::AFE_H_HI;
        end
      end
      afe_pkg::AFE_H_HI: begin
        if (half_done) begin
          rx_d = {rx_q[6:0], link.sdo_line};
          sh_d = {sh_q[14:0], 1'b0};
          if (bit_q == afe_pkg::HOST_LAST) begin
            sck_d = mode11;
            st_d  = afe_pkg::AFE_H_TAIL;
          end else begin
            bit_d = bit_q + 4'h1;
            sck_d = 1'b0;
            sdi_d = (cmd[0] && bit_q >= 4'h7) ? 1'b0 : sh_d[15];
            st_d  = afe_pkg::AFE_H_LO;
          end
        end
      end
      afe_pkg::AFE_H_TAIL: begin
        if (half_done) begin
          cs_d = 1'b1;
          st_d = afe_pkg::AFE_H_IDLE;
        end
      end
      default: st_d = afe_pkg::AFE_H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q    <= afe_pkg::AFE_H_IDLE;
      ctrl_q  <= afe_pkg::CTRL_RESET;
      hc_q    <= '0;
      bit_q   <= 4'h0;
      sh_q    <= 16'h0;
      rx_q    <= 8'h00;
      cs_q    <= 1'b1;
      sck_q   <= 1'b0;
      sdi_q   <= 1'b0;
      rdack_q <= 1'b0;
      rdata_q <= 32'h0;
      ext_q   <= '0;
      clk_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      ctrl_q  <= ctrl_d;
      hc_q    <= hc_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      rx_q    <= rx_d;
      cs_q    <= cs_d;
      sck_q   <= sck_d;
      sdi_q   <= sdi_d;
      rdack_q <= rdack_d;
      rdata_q <= rdata_d;
      ext_q   <= ext_d;
      clk_q   <= clk_d;
    end
  end

  assign avs_waitrequest_o    = avs_read_i & ~rdack_q;
  assign avs_readdata_o       = rdata_q;
  assign link.cs_n            = cs_q;
  assign link.sck             = sck_q;
  assign link.sdi             = sdi_q;
  assign link.mreset_n        = ctrl_q[afe_pkg::CTRL_RSTN_BIT];
  assign link.clock_input_pin = clk_q;
endmodule

// ==== bench/afe_link_assertions.sv ====
`timescale 1ns/1ns
module afe_link_assertions (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic conversion_ready_n,
  input wire logic conversion_ready_oe,
  input wire logic mreset_n
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ----
  // Link sequences
  // ----
  sequence s_cmd_open;
    $fell(cs_n) ##1 !cs_n [*7];
  endsequence

  sequence s_pulse_start;
    $fell(conversion_ready_n);
  endsequence

  AST_CMD_QUIET: assert property (s_cmd_open |-> !sdo_oe)
    else $error("data out driven during command byte");
  AST_DESELECT_OFF: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("data out driven while deselected");
  AST_MRESET_QUIET: assert property (!mreset_n [*4] |-> !sdo_oe && conversion_ready_n && !conversion_ready_oe)
    else $error("pins active during master reset");
  AST_OE_START: assert property ($rose(sdo_oe) |-> !cs_n && !sck && mreset_n)
    else $error("data out enabled outside a read phase");
  AST_SDO_ON_FALL: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sck)
    else $error("data out changed while clock high");
  AST_PULSE_DRIVEN: assert property (!conversion_ready_n |-> conversion_ready_oe)
    else $error("ready pulse not driven");
  AST_PULSE_WIDTH: assert property (s_pulse_start |-> (!conversion_ready_n || !mreset_n) [*4])
    else $error("ready pulse too short");
  AST_PULSE_GAP: assert property ($rose(conversion_ready_n) |-> conversion_ready_n [*8])
    else $error("ready pulses too close");
endmodule

// ==== bench/test_afe_serial_port_ready_reset.sv ====
`timescale 1ns/1ns
module test_afe_serial_port_ready_reset;
  localparam int OSC_DIV  = 2;
  localparam int EXT_HALF = 8;
  logic        sys_clk;
  logic        sys_rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  config_val;
  logic [31:0] rd_word;
  logic [31:0] seed;
  int          fail_count;
  int          num_checks;

  afe_link_if link ();
  afe_dev_end #(.OSC_DIV(OSC_DIV)) i_afe_dev_end (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .link(link),
    .config_o(config_val), .sample_count_o(), .ready_low_o());
  afe_host_end #(.EXT_HALF(EXT_HALF)) i_afe_host_end (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .link(link),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest));
  afe_link_assertions i_afe_link_assertions (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .cs_n(link.cs_n),
    .sck(link.sck), .sdo(link.sdo), .sdo_oe(link.sdo_oe), .conversion_ready_n(link.conversion_ready_n),
    .conversion_ready_oe(link.conversion_ready_oe), .mreset_n(link.mreset_n));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----
  // Checking and closing
  // ----
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----
  // Avalon master and link walks
  // ----
  task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    avs_write <= 1'b0;
  endtask

  task automatic av_rd(input logic [3:0] a);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd_word = avs_readdata;
    avs_read <= 1'b0;
  endtask

  function automatic logic [31:0] ctrl_word(input logic go, rstn, mode, ext, input logic [7:0] cmd, wd);
    ctrl_word = {8'h00, wd, cmd, 4'h0, ext, mode, rstn, go};
  endfunction

  task automatic xfer(input logic rstn, mode, ext, input logic [7:0] cmd, wd);
    av_wr(afe_pkg::HOST_CTRL_OFS, ctrl_word(1'b0, rstn, mode, ext, cmd, wd));
    av_wr(afe_pkg::HOST_CTRL_OFS, ctrl_word(1'b1, rstn, mode, ext, cmd, wd));
    rd_word = 32'h1;
    for (int i = 0; i < 300 && rd_word[0] !== 1'b0; i++) av_rd(afe_pkg::HOST_STAT_OFS);
    chk_val({31'h0, rd_word[0]}, 32'h0);
  endtask

  task automatic to_fall(output int n);
    n = 0;
    while (link.ready_line === 1'b0 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    while (link.ready_line !== 1'b0 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic measure(output int lw, output int per);
    int n;
    to_fall(n);
    lw = 0;
    while (link.ready_line === 1'b0 && lw < 20000) begin
      @(posedge sys_clk);
      lw++;
    end
    to_fall(n);
    per = lw + n;
  endtask

  initial begin
    #400000;
    fail_count++;
    complete_run();
  end

  initial begin
    logic       mode;
    logic       ext;
    logic       idle;
    logic [1:0] pre;
    logic [7:0] cfg;
    int         lw;
    int         per;
    int         tick;
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    seed = 32'h5e59;
    fail_count = 0;
    num_checks = 0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_val({24'h0, config_val}, {24'h0, afe_pkg::CFG_RESET});
    av_rd(4'h8);
    chk_val(rd_word, 32'h0);
    for (int it = 0; it < 4; it++) begin
      mode = 1'($random(seed));
      idle = 1'($random(seed));
      ext = (it == 3);
      pre = ext ? 2'h0 : 2'($random(seed));
      cfg = {1'b0, ext, idle, 3'h0, pre};
      xfer(1'b1, mode, ext, 8'h00, cfg);
      chk_val({24'h0, config_val}, {24'h0, cfg});
      xfer(1'b1, mode, ext, 8'h01, 8'h5a);
      av_rd(afe_pkg::HOST_STAT_OFS);
      chk_val({24'h0, rd_word[15:8]}, {24'h0, cfg});
      tick = ext ? 2 * EXT_HALF : OSC_DIV;
      fork
        measure(lw, per);
        xfer(1'b1, mode, ext, 8'h03, 8'h00);
      join
      chk_cnt(lw, 2 * (1 << pre) * tick);
      chk_cnt(per, 128 * (1 << pre) * tick);
      repeat (lw + 2) @(posedge sys_clk);
      chk_val({31'h0, link.conversion_ready_oe}, {31'h0, idle});
    end
    xfer(1'b1, 1'b0, 1'b0, 8'h0b, 8'h00);
    av_rd(afe_pkg::HOST_STAT_OFS);
    chk_val({24'h0, rd_word[15:8]}, 32'h0);
    xfer(1'b0, 1'b0, 1'b0, 8'h00, 8'h2f);
    chk_val({24'h0, config_val}, {24'h0, afe_pkg::CFG_RESET});
    av_wr(afe_pkg::HOST_CTRL_OFS, ctrl_word(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00));
    measure(lw, per);
    chk_cnt(lw, 2 * OSC_DIV);
    chk_cnt(per, 1024 * OSC_DIV);
    complete_run();
  end
endmodule
